// file: core/stpg_top.sv
// per-port tree-state gate for a five-port switch: register file, frame decision gating, two-entry buffer
// assumes a classic wishbone master and a lookup stage that hands one decision per frame
//
// What the document requires of this block and the processor
// R1 - host port five is never state gated
// R2 - each network port has its own control register
// R3 - disabled: no frames, no learning
// R4 - disabled: override hits may still reach processor
// R5 - blocking: only processor-bound frames, no learning
// R6 - listening: processor frames only, learning off
// R7 - learning: processor frames only, learning on
// R8 - forwarding: normal traffic and learning
// R9 - processor discards disabled-port frames, sends none
// R10 - processor sends nothing to blocking ports
// R11 - processor loads override entries for its frames
// R12 - processor may send via tail tag
// R13 - processor frames use only port five
// R14 - only tail tag bits 3:0 select ports
// R15 - override hits bypass enable gating
`default_nettype none
module stpg_top #(
  parameter int unsigned ADR_W = 10  // wishbone byte address width
) (
  // clock and reset
  input  wire  logic         CLK,
  input  wire  logic         RESETN,
  // wishbone slave
  input  wire  logic         WB_CYC_I,
  input  wire  logic         WB_STB_I,
  input  wire  logic         WB_WE_I,
  input  wire  logic [ADR_W-1:0] WB_ADR_I,
  input  wire  logic [3:0]   WB_SEL_I,
  input  wire  logic [31:0]  WB_DAT_I,
  output var   logic [31:0]  WB_DAT_O,
  output var   logic         WB_ACK_O,
  // frame decision in from lookup
  input  wire  logic         IN_VALID,
  output var   logic         IN_READY,
  input  wire  logic [2:0]   IN_SRC,
  input  wire  logic [4:0]   IN_DST,
  input  wire  logic         IN_OVR,
  input  wire  logic [7:0]   IN_TAG,
  // gated decision out to queueing
  output var   logic         OUT_VALID,
  input  wire  logic         OUT_READY,
  output var   logic [2:0]   OUT_SRC,
  output var   logic [4:0]   OUT_DST,
  output var   logic         OUT_LEARN
);

  // refuse address widths too narrow for the index slice [9:2] taken below
  if (ADR_W < 10) begin : g_bad_adr
    $error("ADR_W must be at least 10");
  end

  // register state
  logic [7:0]  ctrl_r [stpg_pkg::NPORT];  // per-port tree control
  logic [7:0]  global_r;                  // global control
  logic [7:0]  drops_r;                   // saturating drop count
  logic        ack_r;                     // wishbone acknowledge
  logic [31:0] dat_r;                     // wishbone read data

  // buffer state
  logic        out_v_r;                   // head entry valid
  logic [2:0]  out_src_r;                 // head source
  logic [4:0]  out_dst_r;                 // head destinations
  logic        out_lrn_r;                 // head learn flag
  logic        skid_v_r;                  // spare entry valid
  logic [2:0]  skid_src_r;                // spare source
  logic [4:0]  skid_dst_r;                // spare destinations
  logic        skid_lrn_r;                // spare learn flag
  logic        in_rdy_r;                  // room for one more decision

  // decode a register index to a port slot, NPORT when none
  function automatic logic [2:0] port_of(input logic [7:0] idx);
    case (idx)
      stpg_pkg::IDX_P1_CTRL: port_of = 3'h0;
      stpg_pkg::IDX_P2_CTRL: port_of = 3'h1;
      stpg_pkg::IDX_P3_CTRL: port_of = 3'h2;
      stpg_pkg::IDX_P4_CTRL: port_of = 3'h3;
      default:               port_of = 3'h4;
    endcase
  endfunction : port_of

  // bus decode
  logic [7:0] idx;       // word index
  logic [2:0] slot;      // addressed port slot
  logic       bus_req;   // new request this cycle
  logic       wr_lo;     // write reaching byte lane 0
  assign idx     = WB_ADR_I[9:2];
  assign slot    = port_of(idx);
  assign bus_req = WB_CYC_I && WB_STB_I && !ack_r;
  assign wr_lo   = bus_req && WB_WE_I && WB_SEL_I[0];

  // per-port control registers, one per port
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      for (int i = 0; i < stpg_pkg::NPORT; i++) ctrl_r[i] <= stpg_pkg::CTRL_RST;
    end else if (wr_lo && slot < 3'h4) begin
      ctrl_r[slot[1:0]] <= WB_DAT_I[7:0];  // [R2]
    end
  end

  // global control register
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      global_r <= stpg_pkg::GLOBAL_RST;
    end else if (wr_lo && idx == stpg_pkg::IDX_GLOBAL) begin
      global_r <= WB_DAT_I[7:0];
    end
  end

  // acknowledge every request once, unmapped ones too
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= bus_req;
    end
  end

  // read data, zero for unmapped words and upper bits
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      dat_r <= 32'h0000_0000;
    end else if (bus_req && !WB_WE_I) begin
      if (slot < 3'h4) dat_r <= {24'h00_0000, ctrl_r[slot[1:0]]};
      else if (idx == stpg_pkg::IDX_GLOBAL) dat_r <= {24'h00_0000, global_r};
      else if (idx == stpg_pkg::IDX_DROPS) dat_r <= {24'h00_0000, drops_r};
      else dat_r <= 32'h0000_0000;
    end
  end

  // per-port setting vectors
  logic [3:0] tx_en;   // transmit enable per port
  logic [3:0] rx_en;   // receive enable per port
  logic [3:0] ld;      // learning disable per port
  always_comb begin
    for (int i = 0; i < stpg_pkg::NPORT; i++) begin
      tx_en[i] = ctrl_r[i][stpg_pkg::TX_BIT];
      rx_en[i] = ctrl_r[i][stpg_pkg::RX_BIT];
      ld[i]    = ctrl_r[i][stpg_pkg::LD_BIT];
    end
  end

  // gating of one decision
  logic       host_src;  // frame came from the processor
  logic       net_src;   // frame came from ports one to four
  logic [1:0] sp;        // source port slot
  logic       tail_en;   // tail tagging on
  logic [4:0] dst_sel;   // destinations before gating
  logic [4:0] gated;     // destinations after gating
  logic       learn;     // learn the source address
  assign host_src = IN_SRC == stpg_pkg::HOST_PORT;
  assign net_src  = IN_SRC >= 3'h1 && IN_SRC <= 3'h4;
  assign sp       = 2'(IN_SRC - 3'h1);
  assign tail_en  = global_r[stpg_pkg::TAIL_BIT];

  always_comb begin
    // host frames steer by the low tag nibble only while tail tagging is on
    if (host_src && tail_en) begin
      dst_sel = {1'b0, IN_TAG[stpg_pkg::TAG_MSB:0]};  // [R14]
    end else begin
      dst_sel = IN_DST;
    end
    gated = 5'h00;
    learn = 1'b0;
    if (host_src) begin
      // processor traffic is not state gated, never hairpinned
      gated = dst_sel & stpg_pkg::NET_MASK;  // [R1] [R13]
      learn = 1'b1;  // [R1]
    end else if (net_src) begin
      // forwarding: normal traffic to ports that may transmit
      if (rx_en[sp]) begin
        gated = dst_sel & {1'b1, tx_en | {4{IN_OVR}}};  // [R8] [R15]
      end else if (IN_OVR) begin
        // non-forwarding: override hits reach the processor only
        gated = dst_sel & stpg_pkg::HOST_MASK;  // [R4] [R5] [R6] [R7] [R15]
      end else begin
        // disabled, blocking, listening, learning: drop
        gated = 5'h00;  // [R3] [R5] [R6] [R7]
      end
      learn = !ld[sp];  // [R3] [R5] [R6] [R7] [R8]
    end
  end

  // two-entry buffer control
  logic accept;    // decision taken this cycle
  logic drain;     // head leaves or is empty
  assign accept = IN_VALID && in_rdy_r;
  assign drain  = !out_v_r || OUT_READY;

  // head entry
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      out_v_r   <= 1'b0;
      out_src_r <= 3'h0;
      out_dst_r <= 5'h00;
      out_lrn_r <= 1'b0;
    end else if (drain) begin
      if (skid_v_r) begin
        out_v_r   <= 1'b1;
        out_src_r <= skid_src_r;
        out_dst_r <= skid_dst_r;
        out_lrn_r <= skid_lrn_r;
      end else if (accept) begin
        out_v_r   <= 1'b1;
        out_src_r <= IN_SRC;
        out_dst_r <= gated;
        out_lrn_r <= learn;
      end else begin
        out_v_r <= 1'b0;
      end
    end
  end

  // spare entry absorbs a decision while the head is stalled
  logic skid_v_nxt;  // spare valid next cycle
  always_comb begin
    skid_v_nxt = skid_v_r;
    if (drain && skid_v_r) skid_v_nxt = accept;
    else if (!drain && accept) skid_v_nxt = 1'b1;
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      skid_v_r   <= 1'b0;
      skid_src_r <= 3'h0;
      skid_dst_r <= 5'h00;
      skid_lrn_r <= 1'b0;
      in_rdy_r   <= 1'b0;
    end else begin
      skid_v_r <= skid_v_nxt;
      in_rdy_r <= !skid_v_nxt;
      if (accept && (skid_v_r || !drain)) begin
        skid_src_r <= IN_SRC;
        skid_dst_r <= gated;
        skid_lrn_r <= learn;
      end
    end
  end

  // count decisions that were gated to nothing
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      drops_r <= 8'h00;
    end else if (accept && gated == 5'h00 && drops_r != stpg_pkg::DROP_MAX) begin
      drops_r <= drops_r + 8'h01;
    end
  end

  // outputs straight from flops
  assign WB_ACK_O  = ack_r;
  assign WB_DAT_O  = dat_r;
  assign IN_READY  = in_rdy_r;
  assign OUT_VALID = out_v_r;
  assign OUT_SRC   = out_src_r;
  assign OUT_DST   = out_dst_r;
  assign OUT_LEARN = out_lrn_r;

  // checks
  AST_ACK_ONE: assert property (@(posedge CLK) disable iff (!RESETN)  // [R2]
    WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O ##1 !WB_ACK_O)
    else $error("ack not a single cycle after request");

  AST_CTRL_WRITE: assert property (@(posedge CLK) disable iff (!RESETN)  // [R2]
    bus_req && WB_WE_I && WB_SEL_I[0] && idx == stpg_pkg::IDX_P3_CTRL
    |=> ctrl_r[2] == $past(WB_DAT_I[7:0]))
    else $error("port control write lost");

  AST_BLOCK_DROP: assert property (@(posedge CLK) disable iff (!RESETN)  // [R3]
    accept && net_src && !rx_en[sp] && !IN_OVR |-> gated == 5'h00)
    else $error("frame passed a non-receiving port");

  AST_OVR_HOST: assert property (@(posedge CLK) disable iff (!RESETN)  // [R4]
    accept && net_src && !rx_en[sp] && IN_OVR |-> gated == (IN_DST & stpg_pkg::HOST_MASK))
    else $error("override hit not limited to processor");

  AST_TX_GATE: assert property (@(posedge CLK) disable iff (!RESETN)  // [R8]
    accept && net_src && !IN_OVR |-> (gated[3:0] & ~tx_en) == 4'h0)
    else $error("frame sent to non-transmitting port");

  AST_LEARN_OUT: assert property (@(posedge CLK) disable iff (!RESETN)  // [R7]
    accept && net_src && drain && !skid_v_r |=> OUT_VALID && OUT_LEARN == !$past(ld[sp]))
    else $error("learn flag does not follow learning disable");

  AST_HOST_TAG: assert property (@(posedge CLK) disable iff (!RESETN)  // [R14]
    accept && host_src && tail_en && drain && !skid_v_r
    |=> OUT_DST == {1'b0, $past(IN_TAG[3:0])})
    else $error("tail tag did not steer destinations");

  AST_HOST_FREE: assert property (@(posedge CLK) disable iff (!RESETN)  // [R1]
    accept && host_src && !tail_en |-> gated == (IN_DST & stpg_pkg::NET_MASK) && learn)
    else $error("processor frame was state gated");

  AST_HOLD: assert property (@(posedge CLK) disable iff (!RESETN)
    OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_DST) && $stable(OUT_SRC))
    else $error("stalled decision changed or vanished");

endmodule : stpg_top
`default_nettype wire

// file: core/stpg_pkg.sv
// constants for the per-port tree-state gate: register indices, field positions, reset values
// assumes a classic wishbone master that addresses 32-bit words, byte address = 4 * index
`default_nettype none
package stpg_pkg;
  localparam int unsigned NPORT        = 4;        // gated network ports
  localparam int unsigned IDX_W        = 8;        // width of a register index
  localparam logic [7:0]  IDX_P1_CTRL  = 8'h12;    // port1_tree_control
  localparam logic [7:0]  IDX_P2_CTRL  = 8'h22;    // port2_tree_control
  localparam logic [7:0]  IDX_P3_CTRL  = 8'h32;    // port3_tree_control
  localparam logic [7:0]  IDX_P4_CTRL  = 8'h42;    // port4_tree_control
  localparam logic [7:0]  IDX_GLOBAL   = 8'h0c;    // global control, tail tag enable
  localparam logic [7:0]  IDX_DROPS    = 8'h03;    // read-only count of fully gated frames
  localparam int unsigned TX_BIT       = 2;        // transmit enable
  localparam int unsigned RX_BIT       = 1;        // receive enable
  localparam int unsigned LD_BIT       = 0;        // learning disable
  localparam int unsigned TAIL_BIT     = 1;        // tail tag enable in global control
  localparam logic [7:0]  CTRL_RST     = 8'h06;    // forwarding after reset
  localparam logic [7:0]  GLOBAL_RST   = 8'h00;    // tail tagging off after reset
  localparam logic [2:0]  HOST_PORT    = 3'h5;     // processor port number
  localparam int unsigned HOST_BIT     = 4;        // host bit in a destination mask
  localparam logic [4:0]  NET_MASK     = 5'h0f;    // network ports in a destination mask
  localparam logic [4:0]  HOST_MASK    = 5'h10;    // host port alone
  localparam int unsigned TAG_MSB      = 3;        // highest tail tag bit that selects ports
  localparam logic [7:0]  DROP_MAX     = 8'hff;    // drop counter saturates here
endpackage : stpg_pkg
`default_nettype wire

// file: tb/stpg_host_model.sv
// model of the processor side: takes gated decisions, stalls on request
// assumes the gate's output handshake and a single clock
`default_nettype none
module stpg_host_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // gated decision stream
  input  wire logic       out_valid,
  output var  logic       out_ready,
  input  wire logic [2:0] out_src,
  input  wire logic [4:0] out_dst,
  input  wire logic       out_learn,
  // bench control
  input  wire logic       stall,
  input  wire logic [3:0] off_ports
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] got_q[$];  // taken decisions: src, dst, learn
  int         discards;  // host frames thrown away
  // take on ready, ready low while stalled
  always @(posedge clk) begin
    out_ready <= resetn & !stall;
    if (resetn && out_valid && out_ready) begin
      got_q.push_back({out_src, out_dst, out_learn});
      // frames from disabled ports are discarded
      if (out_dst[4] && out_src inside {[1:4]} && off_ports[out_src-3'h1]) discards++;
    end
  end
endmodule : stpg_host_model
`default_nettype wire

// file: tb/spanning_tree_port_gate_bench.sv
// self-checking bench: registers, gating in every state, tail tag, stall
// assumes package, gate and host model compiled first
`default_nettype none
module spanning_tree_port_gate_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CLK, RESETN, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O;
  logic [9:0]  WB_ADR_I;
  logic [3:0]  WB_SEL_I;
  logic [31:0] WB_DAT_I, WB_DAT_O, rd;
  logic        IN_VALID, IN_READY, IN_OVR, OUT_VALID, OUT_READY, OUT_LEARN, stall, tail;
  logic [2:0]  IN_SRC, OUT_SRC;
  logic [4:0]  IN_DST, OUT_DST;
  logic [7:0]  IN_TAG, drops;
  logic [3:0]  off;       // ports in disabled state
  logic [3:0]  sel;       // byte enables for the next bus cycle
  logic [2:0]  ctrl[4];   // tx rx ld per port
  logic [8:0]  e[3];      // expected after stall
  int          miscompares, comparisons;
  stpg_top dut (.CLK(CLK), .RESETN(RESETN), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
    .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
    .IN_VALID(IN_VALID), .IN_READY(IN_READY), .IN_SRC(IN_SRC), .IN_DST(IN_DST), .IN_OVR(IN_OVR),
    .IN_TAG(IN_TAG), .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY), .OUT_SRC(OUT_SRC), .OUT_DST(OUT_DST),
    .OUT_LEARN(OUT_LEARN));
  stpg_host_model p (.clk(CLK), .resetn(RESETN), .out_valid(OUT_VALID), .out_ready(OUT_READY),
    .out_src(OUT_SRC), .out_dst(OUT_DST), .out_learn(OUT_LEARN), .stall(stall), .off_ports(off));
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one classic bus cycle, held until ack
  task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] d);
    @(posedge CLK);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I  <= we;
    WB_SEL_I <= sel;
    WB_ADR_I <= {idx, 2'b00};
    WB_DAT_I <= {24'h0, d};
    do @(posedge CLK); while (WB_ACK_O !== 1'b1);
    rd = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
  endtask : wb
  // write a port's state bits
  task automatic set_port(input int i, input logic [2:0] b);
    wb(1'b1, {i[3:0] + 4'h1, 4'h2}, {5'h0, b});
    ctrl[i] = b;
  endtask : set_port
  // gated result worked out from the state bits
  function automatic logic [8:0] exd(input logic [2:0] s, input logic [4:0] d, input logic o, input logic [7:0] t);
    logic [3:0] txv;
    logic [4:0] m;
    logic       l;
    for (int i = 0; i < 4; i++) txv[i] = ctrl[i][2];
    m = 5'h0;
    l = 1'b0;
    if (s == 3'h5) begin  // host frames, never state gated
      m = {1'b0, tail ? t[3:0] : d[3:0]};
      l = 1'b1;
    end else if (s inside {[1:4]}) begin
      if (ctrl[s-3'h1][1]) m = d & {1'b1, txv | {4{o}}};
      else if (o) m = d & 5'h10;
      l = !ctrl[s-3'h1][0];
    end
    return {s, m, l};
  endfunction : exd
  // offer one decision until taken
  task automatic send(input logic [2:0] s, input logic [4:0] d, input logic o, input logic [7:0] t);
    @(posedge CLK);
    IN_VALID <= 1'b1;
    IN_SRC   <= s;
    IN_DST   <= d;
    IN_OVR   <= o;
    IN_TAG   <= t;
    do @(posedge CLK); while (IN_READY !== 1'b1);
    IN_VALID <= 1'b0;
  endtask : send
  // send, then judge what the host model took
  task automatic run(input logic [2:0] s, input logic [4:0] d, input logic o, input logic [7:0] t);
    logic [8:0] x;
    x = exd(s, d, o, t);
    if (x[5:1] == 5'h0) drops++;
    send(s, d, o, t);
    for (int i = 0; i < 20 && p.got_q.size() == 0; i++) @(posedge CLK);
    chk({23'h0, p.got_q.pop_front()}, {23'h0, x});
  endtask : run
  // reset values, unmapped and read-only places
  task automatic t_regs;
    for (int i = 0; i < 4; i++) begin
      wb(1'b0, {i[3:0] + 4'h1, 4'h2}, 8'h0);
      chk(rd, 32'h6);
    end
    wb(1'b1, 8'h03, 8'h55);
    wb(1'b0, 8'h03, 8'h0);
    chk(rd, 32'h0);
    wb(1'b0, 8'h0c, 8'h0);
    chk(rd, 32'h0);
    wb(1'b1, 8'h22, 8'ha5);
    wb(1'b0, 8'h22, 8'h0);
    chk(rd, 32'ha5);
    // write without lane 0 must leave the register alone
    sel = 4'h2;
    wb(1'b1, 8'h22, 8'h01);
    sel = 4'h1;
    wb(1'b0, 8'h22, 8'h0);
    chk(rd, 32'ha5);
    wb(1'b1, 8'h22, 8'h06);
    wb(1'b1, 8'h50, 8'h55);
    wb(1'b0, 8'h50, 8'h0);
    chk(rd, 32'h0);
  endtask : t_regs
  // every tree state on ports one and three
  task automatic t_states;
    logic [2:0] st[5] = '{3'b001, 3'b001, 3'b001, 3'b000, 3'b110};
    for (int k = 0; k < 5; k++) begin
      set_port(0, st[k]);
      set_port(2, st[k]);
      off <= (k == 0) ? 4'h5 : 4'h0;
      for (int o = 0; o < 2; o++) begin
        run(3'h1, 5'h1e, o[0], 8'h0);
        run(3'h2, 5'h15, o[0], 8'h0);
      end
    end
    // one override hit from disabled port one reached the host
    chk(32'(p.discards), 32'h1);
  endtask : t_states
  // host frames with tag off and on, then a source-zero frame, all ports forwarding
  task automatic t_host;
    run(3'h5, 5'h1f, 1'b0, 8'hf9);
    wb(1'b1, 8'h0c, 8'h02);
    tail = 1'b1;
    run(3'h5, 5'h13, 1'b0, 8'hf9);
    run(3'h0, 5'h1f, 1'b1, 8'h0);
  endtask : t_host
  // stalled receiver: buffer fills, refuses, loses nothing
  task automatic t_stall;
    e = '{exd(3'h1, 5'h02, 1'b0, 8'h00), exd(3'h2, 5'h01, 1'b0, 8'h00), exd(3'h3, 5'h10, 1'b0, 8'h00)};
    stall <= 1'b1;
    fork
      begin
        send(3'h1, 5'h02, 1'b0, 8'h0);
        send(3'h2, 5'h01, 1'b0, 8'h0);
        send(3'h3, 5'h10, 1'b0, 8'h0);
      end
    join_none
    repeat (12) @(posedge CLK);
    chk({31'h0, IN_READY}, 32'h0);
    stall <= 1'b0;
    wait fork;
    repeat (6) @(posedge CLK);
    for (int i = 0; i < 3; i++) chk({23'h0, p.got_q.pop_front()}, {23'h0, e[i]});
    wb(1'b0, 8'h03, 8'h0);
    chk(rd, {24'h0, drops});
  endtask : t_stall
  // print counts and verdict, end the run
  task automatic give_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  // clock
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  // watchdog
  initial begin
    repeat (20000) @(posedge CLK);
    miscompares++;
    give_verdict();
  end
  // main sequence
  initial begin
    {RESETN, WB_CYC_I, WB_STB_I, WB_WE_I, IN_VALID, IN_OVR, stall, tail} = '0;
    {WB_ADR_I, WB_DAT_I, IN_SRC, IN_DST, IN_TAG, drops, off} = '0;
    WB_SEL_I = 4'h1;
    sel = 4'h1;
    for (int i = 0; i < 4; i++) ctrl[i] = 3'b110;
    repeat (8) @(posedge CLK);
    RESETN <= 1'b1;
    t_regs();
    t_states();
    t_host();
    t_stall();
    give_verdict();
  end
endmodule : spanning_tree_port_gate_bench
`default_nettype wire
